/* File: common/pllc_regs.vh */
`ifndef PLLC_REGS_VH
`define PLLC_REGS_VH

// ==========================================
// special function register map
`define PLLC_SFR_ADDR_W 8
`define PLLC_DATA_W 8
`define PLLC_CLK_CTRL_ADDR 8'hd7
`define PLLC_CLK_CTRL_RESET 8'h03
`define PLLC_READ_ZERO 8'h00

// ==========================================
// clock control field positions
`define PLLC_OSCILLATOR_POWERDOWN_BIT 7
`define PLLC_LOCK_BIT 6
`define PLLC_RSVD_HI_BIT 5
`define PLLC_RSVD_LO_BIT 4
`define PLLC_FAST_INTERRUPT_RESPONSE_BIT 3
`define PLLC_CD_MSB 2
`define PLLC_CD_LSB 0
`define PLLC_CD_W 3
`define PLLC_CD_RESET 3'h3
`define PLLC_CD_FULL 3'h0
`define PLLC_RSVD_ZERO 2'h0

// ==========================================
// reset values of single-bit state
`define PLLC_OSCILLATOR_POWERDOWN_RESET 1'h0
`define PLLC_FAST_INTERRUPT_RESPONSE_RESET 1'h0
`define PLLC_OSC_EN_RESET 1'h1
`define PLLC_LOCK_RESET 1'h0
`define PLLC_TICK_RESET 1'h0

// ==========================================
// loop figures
`define PLLC_REF_HZ 32768
`define PLLC_LOOP_MULT 512
`define PLLC_LOOP_HZ 16777216
`define PLLC_DIV_CNT_W 7
`define PLLC_DIV_CNT_ONE 7'h01
`define PLLC_DIV_CNT_ZERO 7'h00

`endif

/* File: hdl/pllc_clock_control.v */
`timescale 1ns/1ps
`include "pllc_regs.vh"

module pllc_clock_control #(
  parameter LOOP_MULT = `PLLC_LOOP_MULT,
  parameter REF_HZ = `PLLC_REF_HZ
) (
  // clock and reset; clk_i stands for the loop output
  input wire clk_i,
  input wire rst_b_i,
  // special function register port
  input wire [`PLLC_SFR_ADDR_W-1:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [`PLLC_DATA_W-1:0] sfr_wdata_i,
  output reg [`PLLC_DATA_W-1:0] sfr_rdata_o,
  // loop and core status
  input wire loop_tracking_i,
  input wire power_down_mode_i,
  input wire interrupt_active_i,
  // clock outputs
  output reg osc_enable_o,
  output reg core_tick_o,
  output reg [`PLLC_CD_W-1:0] active_divider_o,
  output reg lock_o
);

  // ==========================================
  // integration notes
  // clk_i is the loop output itself
  // multiply and free-run fallback live in the analogue loop
  // core clock leaves as a one-cycle tick, not a gated clock,
  // so no glitch reaches the core when the divider changes
  // read and write in one cycle: read sees the old value
  // status inputs are levels, taken as synchronous to clk_i
  // interrupt_active_i must stay high up to the return
  // divider counter is 7 bits: enough for the slowest setting
  // no clock enable: every flop runs on every edge

  // ==========================================
  // stored fields
  // only writable bits live in flops; lock and reserved bits
  // are never stored, so a stray write cannot make them stick
  reg oscillator_powerdown;
  reg fast_interrupt_response;
  reg [`PLLC_CD_W-1:0] core_clock_divider;
  reg [`PLLC_DIV_CNT_W-1:0] div_cnt;

  // next values of the stored fields
  reg next_oscillator_powerdown;
  reg next_fast_interrupt_response;
  reg [`PLLC_CD_W-1:0] next_core_clock_divider;
  reg [`PLLC_DIV_CNT_W-1:0] next_div_cnt;

  // next values of the registered outputs
  reg [`PLLC_CD_W-1:0] next_divider;
  reg next_core_tick;
  reg next_osc_enable;
  reg next_lock;
  reg [`PLLC_DATA_W-1:0] next_rdata;

  // loop frequency figure kept for reference by integrators
  // informative only, it drives no logic
  localparam integer LOOP_HZ = REF_HZ * LOOP_MULT;

  // ==========================================
  // address decode
  // byte-wide access only; no bit-addressed path into this register
  // writes elsewhere in the sfr space never touch this block
  wire sel;
  wire ctrl_wr;
  wire ctrl_rd;
  assign sel = (sfr_addr_i == `PLLC_CLK_CTRL_ADDR);
  assign ctrl_wr = sfr_wr_i && sel;
  assign ctrl_rd = sfr_rd_i && sel;

  // ==========================================
  // register writes
  // field next values; bits 6..4 of the write data are dropped here
  // a write lands in the fields on the same edge that samples the strobe
  always @* begin
    next_oscillator_powerdown = oscillator_powerdown;
    next_fast_interrupt_response = fast_interrupt_response;
    next_core_clock_divider = core_clock_divider;
    if (ctrl_wr) begin
      next_oscillator_powerdown = sfr_wdata_i[`PLLC_OSCILLATOR_POWERDOWN_BIT];
      next_fast_interrupt_response = sfr_wdata_i[`PLLC_FAST_INTERRUPT_RESPONSE_BIT];
      next_core_clock_divider = sfr_wdata_i[`PLLC_CD_MSB:`PLLC_CD_LSB];
    end
  end

  // field flops; power-on image is 03h with the lock bit shown live
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oscillator_powerdown <= `PLLC_OSCILLATOR_POWERDOWN_RESET;
      fast_interrupt_response <= `PLLC_FAST_INTERRUPT_RESPONSE_RESET;
      core_clock_divider <= `PLLC_CD_RESET;
    end else begin
      oscillator_powerdown <= next_oscillator_powerdown;
      fast_interrupt_response <= next_fast_interrupt_response;
      core_clock_divider <= next_core_clock_divider;
    end
  end

  // ==========================================
  // effective divider
  // fast interrupt forces full rate while in service; the stored
  // divider is left alone, so the selected rate returns by itself
  // switch back on the first edge after interrupt_active_i falls
  always @* begin
    next_divider = core_clock_divider;
    if (fast_interrupt_response && interrupt_active_i) begin
      next_divider = `PLLC_CD_FULL;
    end
  end

  // divide mask: low n bits all ones gives one tick per 2^n cycles
  // n = 0 leaves the mask empty, so every cycle ticks
  wire [`PLLC_DIV_CNT_W-1:0] div_mask;
  genvar gi;
  generate
    for (gi = 0; gi < `PLLC_DIV_CNT_W; gi = gi + 1) begin : g_mask
      assign div_mask[gi] = (gi < next_divider);
    end
  endgenerate

  // ==========================================
  // core tick divider
  // counter restarts on every tick; a divider change uses the new
  // mask at once, so the first new period is at most one new period
  wire tick_now;
  assign tick_now = ((div_cnt & div_mask) == div_mask);

  // counter next value; never wraps, since a tick clears it at the top of its width at the latest
  always @* begin
    next_core_tick = tick_now;
    next_div_cnt = div_cnt + `PLLC_DIV_CNT_ONE;
    if (tick_now) begin
      next_div_cnt = `PLLC_DIV_CNT_ZERO;
    end
  end

  // tick flops; tick held low in reset so the core starts cleanly
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= `PLLC_DIV_CNT_ZERO;
      core_tick_o <= `PLLC_TICK_RESET;
      active_divider_o <= `PLLC_CD_RESET;
    end else begin
      div_cnt <= next_div_cnt;
      core_tick_o <= next_core_tick;
      active_divider_o <= next_divider;
    end
  end

  // ==========================================
  // oscillator enable and lock flag
  // crystal stops only in power-down and only when software asked;
  // every other state keeps the reference, and the loop, alive
  // enable is a flop: power-down entry reaches the pad a cycle later
  always @* begin
    next_osc_enable = 1'b1;
    if (power_down_mode_i && oscillator_powerdown) begin
      next_osc_enable = 1'b0;
    end
    next_lock = loop_tracking_i;
  end

  // status flops; lock reads 0 until the first tracking sample
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_enable_o <= `PLLC_OSC_EN_RESET;
      lock_o <= `PLLC_LOCK_RESET;
    end else begin
      osc_enable_o <= next_osc_enable;
      lock_o <= next_lock;
    end
  end

  // ==========================================
  // read data
  // register image; lock sampled live so software sees the loop
  // state of the read cycle itself, not a copy one cycle old
  // reserved bits 5..4 are tied low and ignore writes
  wire [`PLLC_DATA_W-1:0] ctrl_image;
  assign ctrl_image[`PLLC_OSCILLATOR_POWERDOWN_BIT] = oscillator_powerdown;
  assign ctrl_image[`PLLC_LOCK_BIT] = loop_tracking_i;
  assign ctrl_image[`PLLC_RSVD_HI_BIT:`PLLC_RSVD_LO_BIT] = `PLLC_RSVD_ZERO;
  assign ctrl_image[`PLLC_FAST_INTERRUPT_RESPONSE_BIT] = fast_interrupt_response;
  assign ctrl_image[`PLLC_CD_MSB:`PLLC_CD_LSB] = core_clock_divider;

  // read mux; unmapped addresses and idle cycles read zero,
  // so a stale value never lingers on the bus after a read
  always @* begin
    next_rdata = `PLLC_READ_ZERO;
    if (ctrl_rd) begin
      next_rdata = ctrl_image;
    end
  end

  // read data flop
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= `PLLC_READ_ZERO;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

endmodule

/* File: dv/pllc_clock_control_props.sv */
`timescale 1ns/1ps
// ==========================================
// checker on the block ports
module pllc_cc_props (
  input wire clk_i, input wire rst_b_i, input wire [7:0] sfr_addr_i, input wire sfr_wr_i, input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i, input wire [7:0] sfr_rdata_o, input wire loop_tracking_i,
  input wire power_down_mode_i, input wire interrupt_active_i, input wire osc_enable_o, input wire core_tick_o,
  input wire [2:0] active_divider_o, input wire lock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_LOCK: assert property (1 |=> lock_o == $past(loop_tracking_i)) else $error("lock bad");
  AST_OSC_RUN: assert property (!power_down_mode_i |=> osc_enable_o) else $error("osc off");
  AST_OSC_STOP: assert property (!osc_enable_o |-> $past(power_down_mode_i)) else $error("osc stop");
  AST_DIV: assert property (sfr_wr_i && sfr_addr_i == 8'hd7 ##1 !interrupt_active_i
    |=> active_divider_o == $past(sfr_wdata_i[2:0], 2)) else $error("div bad");
  AST_RD_OTHER: assert property (sfr_rd_i && sfr_addr_i != 8'hd7 |=> sfr_rdata_o == 8'h00) else $error("rd");
  AST_RD_IDLE: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00) else $error("idle rd");
  AST_RD_LOCK: assert property (sfr_rd_i && sfr_addr_i == 8'hd7
    |=> sfr_rdata_o[6] == $past(loop_tracking_i) && sfr_rdata_o[5:4] == 2'h0) else $error("lock rd");
  AST_TICK0: assert property ((active_divider_o == 3'h0)[*2] |-> core_tick_o) else $error("tick");
endmodule
bind pllc_clock_control pllc_cc_props props_u (.*);

/* File: dv/pllc_xtal_model.sv */
`timescale 1ns/1ps
// ==========================================
// crystal: tracking only while it runs, fault breaks it
module pllc_xtal_model (
  input wire run_i,
  input wire fault_i,
  output wire track_o
);
  assign track_o = run_i & !fault_i;
endmodule

/* File: dv/pllc_clock_control_tb.sv */
`timescale 1ns/1ps
module pllc_clock_control_tb;
  reg clk = 0, rst_b = 0, wr = 0, rd = 0, pd = 0, irq = 0, flt = 0;
  reg [7:0] a = 0, d = 0;
  wire [7:0] q;
  wire osc, tick, lk, trk;
  wire [2:0] div;
  integer n_errors = 0, n_tests = 0, i, c;
  // ==========================================
  // clock, crystal and block
  always #5 clk = ~clk;
  pllc_xtal_model xt_u (.run_i(osc), .fault_i(flt), .track_o(trk));
  pllc_clock_control dut_u (.clk_i(clk), .rst_b_i(rst_b), .sfr_addr_i(a), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(d), .sfr_rdata_o(q), .loop_tracking_i(trk), .power_down_mode_i(pd),
    .interrupt_active_i(irq), .osc_enable_o(osc), .core_tick_o(tick), .active_divider_o(div), .lock_o(lk));
  task chk(input [63:0] s, input [7:0] got, input [7:0] exp); begin
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0s exp %h got %h", s, exp, got);
    end
  end endtask
  // one access; read data sits on q when this returns
  task sfr(input w, input [7:0] ad, input [7:0] dat); begin
    @(posedge clk); #1 a = ad; d = dat; wr = w; rd = !w;
    @(posedge clk); #1 wr = 0; rd = 0;
  end endtask
  task wt; begin repeat (3) @(posedge clk); #1; end endtask
  task give_verdict; begin
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  // ==========================================
  // scenarios
  // power-on image, lock shown live
  task sc_reset_value; begin
    sfr(0, 8'hd7, 8'h00);
    chk("rst", q, 8'h43);
  end endtask
  // lock and reserved bits ignore writes
  task sc_read_only; begin
    flt = 1;
    sfr(1, 8'hd7, 8'h72);
    sfr(0, 8'hd7, 8'h00);
    chk("ro", q, 8'h02);
    flt = 0;
  end endtask
  task sc_unmapped; begin
    sfr(0, 8'hd6, 8'h00);
    chk("unmap", q, 8'h00);
  end endtask
  // every divider code; 128 cycles hold a whole number of periods
  task sc_divider; begin
    for (i = 0; i < 8; i = i + 1) begin
      sfr(1, 8'hd7, i);
      wt;
      chk("divout", div, i);
      c = 0;
      repeat (128) begin
        @(posedge clk);
        #1 c = c + tick;
      end
      chk("tick", c, 128 >> i);
    end
  end endtask
  // full rate in service only with the fast bit set
  task sc_fast_int; begin
    sfr(1, 8'hd7, 8'h0b);
    irq = 1;
    wt;
    chk("fast_interrupt_response", div, 8'h00);
    c = 0;
    repeat (8) begin
      @(posedge clk);
      #1 c = c + tick;
    end
    chk("fintick", c, 8'h08);
    irq = 0;
    wt;
    chk("fret", div, 8'h03);
    sfr(1, 8'hd7, 8'h03);
    irq = 1;
    wt;
    chk("nofint", div, 8'h03);
    irq = 0;
  end endtask
  task sc_osc; begin
    sfr(1, 8'hd7, 8'h80);
    pd = 1;
    wt;
    chk("oscpd", {lk, osc}, 8'h00);
    pd = 0;
    sfr(1, 8'hd7, 8'h00);
    pd = 1;
    wt;
    chk("oscon", {lk, osc}, 8'h03);
    pd = 0;
  end endtask
  // reset in mid-run after a write of every field
  task sc_mid_reset; begin
    sfr(1, 8'hd7, 8'h8d);
    @(posedge clk);
    #1 rst_b = 0;
    #1;
    chk("rstq", q, 8'h00);
    chk("rstdiv", div, 8'h03);
    chk("rstpin", {tick, lk, osc}, 8'h01);
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    sfr(0, 8'hd7, 8'h00);
    chk("rst2", q, 8'h43);
  end endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1;
    sc_reset_value;
    sc_read_only;
    sc_unmapped;
    sc_divider;
    sc_fast_int;
    sc_osc;
    sc_mid_reset;
    give_verdict;
  end
endmodule
